// File: pkg/spi_cmd_pkg.sv
package spi_cmd_pkg;

    // ==========================================================
    // Command opcodes and configuration codes
    localparam logic [7:0] OP_REG_WRITE = 8'h20;
    localparam logic [7:0] OP_REG_READ = 8'h21;
    localparam logic [7:0] OP_BIT_ORDER = 8'h18;
    localparam logic [7:0] CFG_MSB_FIRST = 8'h81;
    localparam logic [7:0] CFG_LSB_FIRST = 8'h42;

    // ==========================================================
    // Reset values and counts
    localparam logic RST_MSB_FIRST = 1'b1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] BIT_CNT_FIRST = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned PIN_COUNT = 3;
    localparam int unsigned PIN_SCLK = 0;
    localparam int unsigned PIN_SEL = 1;
    localparam int unsigned PIN_MOSI = 2;

    // ==========================================================
    // Command byte sequencer states, Gray along the usual path
    typedef enum logic [1:0] {
        ST_OPCODE = 2'h0,
        ST_ARG = 2'h1,
        ST_DATA = 2'h3,
        ST_REPLY = 2'h2
    } cmd_state_e;

endpackage : spi_cmd_pkg

// File: hdl/spi_pin_sync.sv
module spi_pin_sync #(
    parameter int unsigned WIDTH = 3
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);

    // ==========================================================
    // Two-flop synchroniser plus one history stage for edges
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] hist;
    } sync_s;

    sync_s q, d;

    // Meta stage only feeds the sync stage
    always_comb begin
        d = q;
        d.meta = pin_in;
        d.sync = q.meta;
        d.hist = q.sync;
    end

    // Resets to all ones: select and clock idle high
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    // Edges come from the settled stages only
    assign level_out = q.sync;
    assign rise_out = q.sync & ~q.hist;
    assign fall_out = ~q.sync & q.hist;

endmodule : spi_pin_sync

// File: hdl/spi_slave_command_port.sv
// Contract
// - Respond only while select is low
// - Register commands anytime, never start I2C
// - Write: 0x20, address, value stored
// - One register per write command
// - Read: 0x21, address, ignored filler
// - Register value shifted out after filler
// - 0x18 then 0x81 MSB or 0x42 LSB
// - Other setting values leave bit order
// - Bit order applies both directions
// - Serial commands are the control path
// - Slave function off during command
// - Stall I2C master until command done
module spi_slave_command_port (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic sclk_in,
    input wire logic slave_select_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    input wire logic [7:0] reg_rdata_in,
    input wire logic i2c_master_active_in,
    output logic i2c_master_stall_out,
    output logic i2c_slave_disable_out,
    output logic lsb_first_out,
    output logic cmd_busy_out
);
    import spi_cmd_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        cmd_state_e st;
        logic [7:0] opcode;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic [7:0] tx;
        logic miso;
        logic msb_first;
        logic busy;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_s;

    core_s q, d;

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_lvl;
    logic [PIN_COUNT-1:0] pin_rise;
    logic [PIN_COUNT-1:0] pin_fall;
    logic selected;
    logic sclk_rise;
    logic sclk_fall;
    logic mosi_bit;
    logic byte_done;
    logic [7:0] rx_next;

    // ==========================================================
    // Input synchronisation
    // All three pins are asynchronous to the core clock
    assign pin_raw[PIN_SCLK] = sclk_in;
    assign pin_raw[PIN_SEL] = slave_select_n_in;
    assign pin_raw[PIN_MOSI] = mosi_in;

    spi_pin_sync #(
        .WIDTH(PIN_COUNT)
    ) u_pin_sync (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .pin_in(pin_raw),
        .level_out(pin_lvl),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // Edges only count while selected
    assign selected = ~pin_lvl[PIN_SEL];
    assign sclk_rise = selected & pin_rise[PIN_SCLK];
    assign sclk_fall = selected & pin_fall[PIN_SCLK];
    assign mosi_bit = pin_lvl[PIN_MOSI];
    assign byte_done = sclk_rise && (q.cnt == BIT_CNT_LAST);

    // ==========================================================
    // Helpers
    // Shift a received bit in at the end that matches bit order
    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_v,
                                             input logic msb);
        if (msb) begin
            shift_in = {cur[6:0], bit_v};
        end else begin
            shift_in = {bit_v, cur[7:1]};
        end
    endfunction : shift_in

    // Recognised opcode check, used by the sequencer
    function automatic logic known_opcode(input logic [7:0] op);
        known_opcode = (op == OP_REG_WRITE) || (op == OP_REG_READ) || (op == OP_BIT_ORDER);
    endfunction : known_opcode

    assign rx_next = shift_in(q.rx, mosi_bit, q.msb_first);

    // ==========================================================
    // Command sequencer
    // Mode with idle-high clock: sample on rising, shift on falling
    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        // Read data is one cycle behind the read strobe
        if (q.rd) begin
            d.tx = reg_rdata_in;
        end
        if (!selected) begin
            // Partial command is dropped, counter back to opcode
            d.st = ST_OPCODE;
            d.cnt = BIT_CNT_FIRST;
            d.rx = RST_BYTE;
            d.busy = 1'b0;
        end else begin
            // Any clock edge starts a command
            if (sclk_rise || sclk_fall) begin
                d.busy = 1'b1;
            end
            // Transmit: next bit out, in the chosen order
            if (sclk_fall) begin
                d.miso = q.msb_first ? q.tx[7] : q.tx[0];
                d.tx = q.msb_first ? {q.tx[6:0], 1'b0} : {1'b0, q.tx[7:1]};
            end
            if (sclk_rise) begin
                d.rx = rx_next;
                d.cnt = q.cnt + 3'h1;
            end
            if (byte_done) begin
                case (q.st)
                    ST_OPCODE: begin
                        d.opcode = rx_next;
                        if (known_opcode(rx_next)) begin
                            d.st = ST_ARG;
                        end else begin
                            // Unknown byte: nothing to do
                            d.busy = 1'b0;
                        end
                    end
                    ST_ARG: begin
                        if (q.opcode == OP_BIT_ORDER) begin
                            if (rx_next == CFG_MSB_FIRST) begin
                                d.msb_first = 1'b1;
                            end else if (rx_next == CFG_LSB_FIRST) begin
                                d.msb_first = 1'b0;
                            end
                            // Other codes leave the order alone
                            d.st = ST_OPCODE;
                            d.busy = 1'b0;
                        end else begin
                            d.addr = rx_next;
                            d.st = ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (q.opcode == OP_REG_WRITE) begin
                            // One register only, then back to opcode
                            d.wr = 1'b1;
                            d.wdata = rx_next;
                            d.st = ST_OPCODE;
                            d.busy = 1'b0;
                        end else begin
                            // Filler is dropped; fetch the current value now
                            d.rd = 1'b1;
                            d.st = ST_REPLY;
                        end
                    end
                    ST_REPLY: begin
                        // Command counts as done once the reply left
                        d.st = ST_OPCODE;
                        d.busy = 1'b0;
                    end
                    default: begin
                        d.st = ST_OPCODE;
                        d.busy = 1'b0;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q.st <= ST_OPCODE;
            q.opcode <= RST_BYTE;
            q.rx <= RST_BYTE;
            q.cnt <= BIT_CNT_FIRST;
            q.tx <= RST_BYTE;
            q.miso <= 1'b0;
            q.msb_first <= RST_MSB_FIRST;
            q.busy <= 1'b0;
            q.wr <= 1'b0;
            q.rd <= 1'b0;
            q.addr <= RST_BYTE;
            q.wdata <= RST_BYTE;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // Register accesses never touch the I2C engine
    assign reg_wr_out = q.wr;
    assign reg_rd_out = q.rd;
    assign reg_addr_out = q.addr;
    assign reg_wdata_out = q.wdata;
    assign miso_out = q.miso;
    assign miso_oe_out = selected;
    assign lsb_first_out = ~q.msb_first;
    assign cmd_busy_out = q.busy;
    // Slave off for the whole command; harmless while master
    assign i2c_slave_disable_out = q.busy;
    // Master transfer frozen until the command is processed
    assign i2c_master_stall_out = q.busy & i2c_master_active_in;

    // ==========================================================
    // Assertions
    a_deselect_idle: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !selected |=> (q.st == ST_OPCODE) && (q.cnt == BIT_CNT_FIRST) && !q.busy)
        else $error("deselect did not discard command");

    a_oe_follows_sel: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        miso_oe_out == ~pin_lvl[PIN_SEL])
        else $error("miso enable while deselected");

    a_write_cause: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        reg_wr_out |-> $past(q.st) == ST_DATA && $past(q.opcode) == OP_REG_WRITE
        && $past(byte_done) && reg_wdata_out == $past(rx_next))
        else $error("write strobe without write command");

    a_write_single: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        reg_wr_out |-> q.st == ST_OPCODE ##1 !reg_wr_out)
        else $error("write command updated more than one register");

    a_read_reply: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        reg_rd_out |=> q.tx == $past(reg_rdata_in) && q.st == ST_REPLY)
        else $error("read value not loaded for reply");

    a_read_after_fill: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        $rose(reg_rd_out) |-> $past(q.opcode) == OP_REG_READ && $past(q.st) == ST_DATA)
        else $error("read strobe before filler byte");

    a_order_keep: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        byte_done && q.st == ST_ARG && q.opcode == OP_BIT_ORDER
        && rx_next != CFG_MSB_FIRST && rx_next != CFG_LSB_FIRST |=> $stable(q.msb_first))
        else $error("bad setting changed bit order");

    a_order_set: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        byte_done && q.st == ST_ARG && q.opcode == OP_BIT_ORDER && rx_next == CFG_LSB_FIRST
        |=> lsb_first_out)
        else $error("lsb setting not applied");

    a_tx_bit_order: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        sclk_fall |=> miso_out == ($past(q.msb_first) ? $past(q.tx[7]) : $past(q.tx[0])))
        else $error("miso bit in wrong order");

    a_stall_busy: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        q.busy && i2c_master_active_in |-> i2c_master_stall_out && i2c_slave_disable_out)
        else $error("i2c not held during command");

    c_write: cover property (@(posedge core_clk_in) disable iff (!arst_n_in) reg_wr_out);
    c_read: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        reg_rd_out ##[1:1000] (q.st == ST_OPCODE));
    c_lsb: cover property (@(posedge core_clk_in) disable iff (!arst_n_in) $fell(q.msb_first));
    c_abort: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        q.st == ST_DATA ##1 !selected);

endmodule : spi_slave_command_port

// File: verification/spi_master_model.sv
module spi_master_model (
    output logic sclk_out,
    output logic slave_select_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Link timing
    // Half period of 80 ns leaves four core cycles per phase;
    // 6.25 MHz also stays clear of the weak band near 100-300 kHz
    localparam time HALF_T = 80ns;

    logic miso_last = 1'b0;
    logic miso_seen;

    // Released MISO reads back inverted so a stale level never matches
    always @(miso_in, miso_oe_in) begin
        if (miso_oe_in === 1'b1) begin
            miso_last = miso_in;
        end
    end
    assign miso_seen = (miso_oe_in === 1'b1) ? miso_in : ~miso_last;

    // Clock parked high, deselected, at time zero
    initial begin
        sclk_out = 1'b1;
        slave_select_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // ==========================================================
    // Select control with settle time on both sides
    task automatic select(input logic on);
        #(HALF_T);
        slave_select_n_out = ~on;
        if (!on) begin
            mosi_out = ~mosi_out;
        end
        #(HALF_T);
    endtask : select

    // One byte: data set after falling edge, MISO taken at rising edge
    task automatic xfer(input logic [7:0] tx, input logic lsb, output logic [7:0] rx);
        int b;
        for (int i = 0; i < 8; i++) begin
            b = lsb ? i : 7 - i;
            sclk_out = 1'b0;
            mosi_out = tx[b];
            #(HALF_T);
            sclk_out = 1'b1;
            rx[b] = miso_seen;
            #(HALF_T);
        end
        mosi_out = ~mosi_out;
    endtask : xfer

endmodule : spi_master_model

// File: verification/spi_slave_command_port_tb_top.sv
module spi_slave_command_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_cmd_pkg::*;

    // ==========================================================
    // Signals and bench state
    logic core_clk_in, arst_n_in, sclk_in, slave_select_n_in, mosi_in, miso_out, miso_oe_out;
    logic reg_wr_out, reg_rd_out, i2c_master_active_in, i2c_master_stall_out;
    logic i2c_slave_disable_out, lsb_first_out, cmd_busy_out, exp_lsb;
    logic [7:0] reg_addr_out, reg_wdata_out, reg_rdata_in, rep, a, d;
    logic [7:0] regs [256];
    logic [7:0] shadow [256];
    logic [7:0] cfg_tab [5] = '{CFG_LSB_FIRST, 8'h55, CFG_MSB_FIRST, 8'hFF, CFG_LSB_FIRST};
    logic [16:0] notes [$];
    logic [16:0] note;
    logic [16:0] seen;
    int error_cnt, total_checks;

    spi_slave_command_port spi_slave_command_port_i (.core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in), .sclk_in(sclk_in), .slave_select_n_in(slave_select_n_in),
        .mosi_in(mosi_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
        .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .reg_addr_out(reg_addr_out),
        .reg_wdata_out(reg_wdata_out), .reg_rdata_in(reg_rdata_in),
        .i2c_master_active_in(i2c_master_active_in),
        .i2c_master_stall_out(i2c_master_stall_out),
        .i2c_slave_disable_out(i2c_slave_disable_out), .lsb_first_out(lsb_first_out),
        .cmd_busy_out(cmd_busy_out));

    spi_master_model spi_master_model_i (.sclk_out(sclk_in),
        .slave_select_n_out(slave_select_n_in), .mosi_out(mosi_in), .miso_in(miso_out),
        .miso_oe_in(miso_oe_out));

    // Clock at 50 MHz
    always #10 core_clk_in = ~core_clk_in;

    // Register file behind the port; read data is combinational
    // Falling edge keeps clear of the edge that launches the strobe
    always @(negedge core_clk_in) begin
        if (reg_wr_out === 1'b1) begin
            regs[reg_addr_out] <= reg_wdata_out;
        end
    end
    assign reg_rdata_in = regs[reg_addr_out];

    // ==========================================================
    // Checking and closing
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    task automatic wrap_up();
        if (notes.size() != 0) begin
            error_cnt++;
            $display("[FAIL] %0t register accesses missing", $time);
        end
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // Every register pulse must match the oldest note; extra pulses fail
    always @(negedge core_clk_in) begin
        if (reg_wr_out === 1'b1 || reg_rd_out === 1'b1) begin
            if (notes.size() == 0) begin
                check(1'b0, "unexpected register access");
            end else begin
                note = notes.pop_front();
                seen = {reg_rd_out, reg_addr_out, (reg_rd_out ? 8'h00 : reg_wdata_out)};
                check(seen === note, "register access mismatch");
            end
        end
    end

    // ==========================================================
    // Command helpers
    task automatic send(input logic [7:0] b, output logic [7:0] r);
        spi_master_model_i.xfer(b, exp_lsb, r);
    endtask : send

    // Write body; caller owns select so commands can run back to back
    task automatic wr_body(input logic [7:0] ad, input logic [7:0] dt);
        send(OP_REG_WRITE, rep);
        send(ad, rep);
        notes.push_back({1'b0, ad, dt});
        send(dt, rep);
        shadow[ad] = dt;
    endtask : wr_body

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        spi_master_model_i.select(1'b1);
        wr_body(ad, dt);
        spi_master_model_i.select(1'b0);
    endtask : wr

    // Read with random filler; reply must equal the last value written
    task automatic rd(input logic [7:0] ad);
        spi_master_model_i.select(1'b1);
        send(OP_REG_READ, rep);
        send(ad, rep);
        notes.push_back({1'b1, ad, 8'h00});
        send(8'($urandom), rep);
        send(8'($urandom), rep);
        spi_master_model_i.select(1'b0);
        check(rep === shadow[ad], "read reply wrong");
    endtask : rd

    // ==========================================================
    // Scenarios
    initial begin
        core_clk_in = 1'b0;
        arst_n_in = 1'b0;
        i2c_master_active_in = 1'b0;
        exp_lsb = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h00;
            shadow[i] = 8'h00;
        end
        void'($urandom(32'h2C5C69F7));
        repeat (6) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        #7;
        check(lsb_first_out === 1'b0 && cmd_busy_out === 1'b0, "reset state wrong");
        // Edges while deselected must do nothing
        send(OP_REG_WRITE, rep);
        send(8'h11, rep);
        check(miso_oe_out === 1'b0 && cmd_busy_out === 1'b0, "deselected activity");
        // Random writes then read back, with and without I2C master running
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            @(posedge core_clk_in);
            i2c_master_active_in <= 1'($urandom);
            wr(a, d);
            rd(a);
        end
        // Partial command under I2C master activity, then abort by deselect
        @(posedge core_clk_in);
        i2c_master_active_in <= 1'b1;
        spi_master_model_i.select(1'b1);
        send(OP_REG_WRITE, rep);
        send(8'h05, rep);
        check(cmd_busy_out === 1'b1 && i2c_master_stall_out === 1'b1, "no stall");
        check(i2c_slave_disable_out === 1'b1, "slave still on");
        check(miso_oe_out === 1'b1, "miso not driven while selected");
        spi_master_model_i.select(1'b0);
        repeat (8) @(posedge core_clk_in);
        check(cmd_busy_out === 1'b0 && i2c_master_stall_out === 1'b0, "abort stuck");
        // Unknown opcode then two writes with select held low
        spi_master_model_i.select(1'b1);
        send(8'h3C, rep);
        wr_body(8'h05, 8'hA5);
        wr_body(8'h06, 8'h5A);
        spi_master_model_i.select(1'b0);
        check(i2c_master_stall_out === 1'b0, "stall after command");
        // Bit order table, each followed by a round trip
        foreach (cfg_tab[k]) begin
            @(posedge core_clk_in);
            i2c_master_active_in <= 1'($urandom);
            spi_master_model_i.select(1'b1);
            send(OP_BIT_ORDER, rep);
            send(cfg_tab[k], rep);
            spi_master_model_i.select(1'b0);
            if (cfg_tab[k] == CFG_LSB_FIRST) exp_lsb = 1'b1;
            else if (cfg_tab[k] == CFG_MSB_FIRST) exp_lsb = 1'b0;
            check(lsb_first_out === exp_lsb, "bit order wrong");
            a = 8'($urandom);
            wr(a, 8'($urandom));
            rd(a);
        end
        repeat (10) @(posedge core_clk_in);
        wrap_up();
    end

    // Run takes about 0.12 ms; allow a wide margin
    initial begin
        #1000000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

endmodule : spi_slave_command_port_tb_top
